// >>> rtl/vout_limit_fault_monitor.sv
// Output-voltage warning and fault limits with undervoltage response.
// Assumes a command engine that decodes host transactions into cmd.
//
// What this block does
// - Above the high warning level set summary and high-warning bits, alert
// - High warning steps 103 to 116 percent by 1, rounded up
// - High warning trip follows the present output target
// - Target changes in absolute format leave stored limits unchanged
// - Below the low warning level set summary and low-warning bits, alert
// - Low warning steps 84 to 97 percent by 1, rounded down
// - Undervoltage fault steps 60 to 95 percent by 2.5, rounded down
// - Fault level follows the target and starts the chosen response
// - Fault sets other, summary and fault bits and alerts in the same cycle
// - Action 00 continue, 01 delayed shutdown, 10 immediate, 11 refused
// - Retry 0 latches, 1 to 6 limited tries, 7 endless tries
// - Delay codes give one, three or seven switching periods
// - Same codes set hiccup length in rise times
// - Written limits become a percentage of the present target
// - Unsupported writes are refused, flagged and alerted
// - Limits use word transfers, action uses byte transfers
// - Values load from the store and act at once
// - One clean rise time after rising clears the retry count
`timescale 1ns/1ps
module vout_limit_fault_monitor (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Command engine
  input  wire limit_pkg::cmd_s       cmd,
  output logic [15:0]                rd_data,
  output logic                       cmd_ack,
  // Converter
  input  wire logic [15:0]           vout_command,
  input  wire logic                  vout_relative,
  input  wire logic [15:0]           vout_sense,
  input  wire logic                  output_on_cmd,
  input  wire logic                  pwm_tick,
  input  wire logic [15:0]           ton_rise_cycles,
  output logic                       power_stage_on,
  output logic [2:0]                 restart_count,
  // Nonvolatile store
  input  wire logic                  nvm_restore,
  input  wire limit_pkg::nvm_image_s nvm_image,
  // Status and notification
  input  wire limit_pkg::status_s    status_clear,
  output limit_pkg::status_s         status,
  output logic                       alert_n
);
  logic [15:0]           ovw_raw_reg;
  logic [15:0]           uvw_raw_reg;
  logic [15:0]           uvf_raw_reg;
  logic [10:0]           ovw_pct_reg;
  logic [10:0]           uvw_pct_reg;
  logic [10:0]           uvf_pct_reg;
  logic [7:0]            action_reg;
  logic [15:0]           rd_data_reg;
  logic                  ack_reg;
  logic                  alert_n_reg;
  logic                  power_on_reg;
  limit_pkg::status_s    status_reg;
  limit_pkg::status_s    status_set;
  limit_pkg::status_s    status_next;
  limit_pkg::state_e     state_reg;
  limit_pkg::state_e     state_next;
  logic [15:0]           tmr_reg;
  logic [15:0]           tmr_next;
  logic [2:0]            unit_reg;
  logic [2:0]            unit_next;
  logic [2:0]            retry_reg;
  logic [2:0]            retry_next;
  logic                  ovw_trip_reg;
  logic                  uvw_trip_reg;
  logic                  uvf_trip_reg;
  logic                  ovw_trip;
  logic                  uvw_trip;
  logic                  uvf_trip;
  logic                  hit_ovw;
  logic                  hit_uvw;
  logic                  hit_uvf;
  logic                  hit_act;
  logic                  hit_limit;
  logic                  req;
  logic                  size_ok;
  logic                  data_ok;
  logic                  wr_good;
  logic                  wr_bad;
  logic [15:0]           rd_value;
  logic [15:0]           q_base;
  logic [10:0]           q_min;
  logic [4:0]            q_step;
  logic [3:0]            q_count;
  logic [10:0]           q_pct;
  logic                  q_ok;
  limit_pkg::uv_action_e act;
  logic [2:0]            retry_code;
  logic [2:0]            dly_code;
  logic [2:0]            unit_inc;
  logic                  monitor;
  logic                  fault_watch;
  logic                  ovw_evt;
  logic                  uvw_evt;
  logic                  uvf_evt;
  logic                  rise_done;
  logic                  retry_left;
  logic                  shut_now;
  limit_pkg::state_e     shut_target;

  // Command decode
  assign hit_ovw   = cmd.code == limit_pkg::CMD_OV_WARN;
  assign hit_uvw   = cmd.code == limit_pkg::CMD_UV_WARN;
  assign hit_uvf   = cmd.code == limit_pkg::CMD_UV_FAULT;
  assign hit_act   = cmd.code == limit_pkg::CMD_UV_ACTION;
  assign hit_limit = hit_ovw | hit_uvw | hit_uvf;
  assign req       = cmd.valid && (hit_limit || hit_act);
  assign size_ok   = hit_limit ? cmd.word : !cmd.word;

  // Step table of the addressed limit
  assign q_min   = hit_ovw ? limit_pkg::OVW_MIN :
                   hit_uvw ? limit_pkg::UVW_MIN : limit_pkg::UVF_MIN;
  assign q_step  = hit_uvf ? limit_pkg::STEP_UVF : limit_pkg::STEP_ONE;
  assign q_count = hit_ovw ? limit_pkg::OVW_COUNT :
                   hit_uvw ? limit_pkg::UVW_COUNT : limit_pkg::UVF_COUNT;
  // Absolute values are referred to the target at the time of writing
  assign q_base  = vout_relative ? limit_pkg::REL_ONE : vout_command;

  limit_quantize u_quant (
    .value    (cmd.data),
    .base     (q_base),
    .min      (q_min),
    .step     (q_step),
    .count    (q_count),
    .round_up (hit_ovw),
    .pct      (q_pct),
    .ok       (q_ok)
  );

  // Acceptance of writes and reads
  assign data_ok = hit_limit ? q_ok :
                   (cmd.data[7:6] != limit_pkg::ACT_INVALID);
  assign wr_good = req && cmd.write && size_ok && data_ok;
  assign wr_bad  = req && !(size_ok && (data_ok || !cmd.write));
  assign rd_value = hit_ovw ? ovw_raw_reg :
                    hit_uvw ? uvw_raw_reg :
                    hit_uvf ? uvf_raw_reg : {8'h00, action_reg};

  // Limit storage; the target itself never rewrites these
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovw_raw_reg <= limit_pkg::OVW_RAW_RST;
      uvw_raw_reg <= limit_pkg::UVW_RAW_RST;
      uvf_raw_reg <= limit_pkg::UVF_RAW_RST;
      ovw_pct_reg <= limit_pkg::OVW_PCT_RST;
      uvw_pct_reg <= limit_pkg::UVW_PCT_RST;
      uvf_pct_reg <= limit_pkg::UVF_PCT_RST;
    end else if (nvm_restore) begin
      ovw_raw_reg <= nvm_image.ovw_raw;
      uvw_raw_reg <= nvm_image.uvw_raw;
      uvf_raw_reg <= nvm_image.uvf_raw;
      ovw_pct_reg <= nvm_image.ovw_pct;
      uvw_pct_reg <= nvm_image.uvw_pct;
      uvf_pct_reg <= nvm_image.uvf_pct;
    end else if (wr_good) begin
      if (hit_ovw) begin
        ovw_raw_reg <= cmd.data;
        ovw_pct_reg <= q_pct;
      end
      if (hit_uvw) begin
        uvw_raw_reg <= cmd.data;
        uvw_pct_reg <= q_pct;
      end
      if (hit_uvf) begin
        uvf_raw_reg <= cmd.data;
        uvf_pct_reg <= q_pct;
      end
    end
  end

  // Response byte and command answer
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      action_reg  <= limit_pkg::ACTION_RST;
      ack_reg     <= 1'b0;
      rd_data_reg <= 16'h0000;
    end else begin
      if (nvm_restore) begin
        action_reg <= nvm_image.action;
      end else if (wr_good && hit_act) begin
        action_reg <= cmd.data[7:0];
      end
      ack_reg     <= req;
      rd_data_reg <= (req && !cmd.write && size_ok) ? rd_value : 16'h0000;
    end
  end

  // Comparators run against the live target every cycle
  limit_compare u_ovw (
    .sense  (vout_sense),
    .target (vout_command),
    .pct    (ovw_pct_reg),
    .below  (1'b0),
    .trip   (ovw_trip)
  );
  limit_compare u_uvw (
    .sense  (vout_sense),
    .target (vout_command),
    .pct    (uvw_pct_reg),
    .below  (1'b1),
    .trip   (uvw_trip)
  );
  limit_compare u_uvf (
    .sense  (vout_sense),
    .target (vout_command),
    .pct    (uvf_pct_reg),
    .below  (1'b1),
    .trip   (uvf_trip)
  );

  // Events only count while the output is meant to be in regulation
  assign monitor     = state_reg == limit_pkg::ST_CONFIRM ||
                       state_reg == limit_pkg::ST_RUN ||
                       state_reg == limit_pkg::ST_DELAY;
  assign fault_watch = state_reg == limit_pkg::ST_CONFIRM ||
                       state_reg == limit_pkg::ST_RUN;
  assign ovw_evt     = monitor && ovw_trip_reg;
  assign uvw_evt     = monitor && uvw_trip_reg;
  assign uvf_evt     = fault_watch && uvf_trip_reg;

  // Sticky status; a new event beats a clear in the same cycle
  assign status_set.vout_summary  = ovw_evt | uvw_evt | uvf_evt;
  assign status_set.none_of_above = uvf_evt;
  assign status_set.ov_warn       = ovw_evt;
  assign status_set.uv_warn       = uvw_evt;
  assign status_set.uv_fault      = uvf_evt;
  assign status_set.cml_data      = wr_bad;
  assign status_next = (status_reg & ~status_clear) | status_set;

  // Response fields
  assign act        = limit_pkg::uv_action_e'(action_reg[7:6]);
  assign retry_code = action_reg[5:3];
  assign dly_code   = action_reg[2:0];
  assign unit_inc   = unit_reg + 3'h1;
  assign rise_done  = ({1'b0, tmr_reg} + 17'h00001) >=
                      {1'b0, ton_rise_cycles};
  assign retry_left = retry_code == limit_pkg::RETRY_FOREVER ||
                      retry_reg < retry_code;
  assign shut_now   = (uvf_evt && act == limit_pkg::ACT_IMMEDIATE) ||
                      (state_reg == limit_pkg::ST_DELAY && pwm_tick &&
                       unit_inc == limit_pkg::delay_periods(dly_code));
  assign shut_target = retry_left ? limit_pkg::ST_HICCUP
                                  : limit_pkg::ST_LATCHED;

  // Shutdown, hiccup and restart sequencing
  always_comb begin
    state_next = state_reg;
    tmr_next   = tmr_reg + 16'h0001;
    unit_next  = unit_reg;
    retry_next = retry_reg;
    case (state_reg)
      limit_pkg::ST_OFF: begin
        tmr_next = 16'h0000;
        if (output_on_cmd) begin
          state_next = limit_pkg::ST_RISE;
        end
      end
      limit_pkg::ST_RISE: begin
        if (rise_done) begin
          state_next = limit_pkg::ST_CONFIRM;
          tmr_next   = 16'h0000;
        end
      end
      limit_pkg::ST_CONFIRM, limit_pkg::ST_RUN: begin
        if (state_reg == limit_pkg::ST_RUN) begin
          tmr_next = 16'h0000;
        end
        unit_next = 3'h0;
        if (shut_now) begin
          state_next = shut_target;
          tmr_next   = 16'h0000;
        end else if (uvf_evt && act == limit_pkg::ACT_DELAYED) begin
          state_next = limit_pkg::ST_DELAY;
        end else if (state_reg == limit_pkg::ST_CONFIRM && rise_done) begin
          state_next = limit_pkg::ST_RUN;
          retry_next = 3'h0;
        end
      end
      limit_pkg::ST_DELAY: begin
        tmr_next = 16'h0000;
        if (shut_now) begin
          state_next = shut_target;
          unit_next  = 3'h0;
        end else if (pwm_tick) begin
          unit_next = unit_inc;
        end
      end
      limit_pkg::ST_HICCUP: begin
        if (rise_done) begin
          tmr_next = 16'h0000;
          if (unit_inc == limit_pkg::hiccup_mult(dly_code)) begin
            state_next = limit_pkg::ST_RISE;
            unit_next  = 3'h0;
            retry_next = retry_reg + 3'h1;
          end else begin
            unit_next = unit_inc;
          end
        end
      end
      limit_pkg::ST_LATCHED: begin
        tmr_next = 16'h0000;
      end
      default: begin
        state_next = limit_pkg::ST_OFF;
      end
    endcase
    if (!output_on_cmd) begin
      state_next = limit_pkg::ST_OFF;
      retry_next = 3'h0;
      unit_next  = 3'h0;
    end
  end

  // Sequencer and status registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= limit_pkg::ST_OFF;
      tmr_reg      <= 16'h0000;
      unit_reg     <= 3'h0;
      retry_reg    <= 3'h0;
      power_on_reg <= 1'b0;
      status_reg   <= '0;
      alert_n_reg  <= 1'b1;
      ovw_trip_reg <= 1'b0;
      uvw_trip_reg <= 1'b0;
      uvf_trip_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      tmr_reg      <= tmr_next;
      unit_reg     <= unit_next;
      retry_reg    <= retry_next;
      power_on_reg <= state_next inside {limit_pkg::ST_RISE,
                      limit_pkg::ST_CONFIRM, limit_pkg::ST_RUN,
                      limit_pkg::ST_DELAY};
      status_reg   <= status_next;
      alert_n_reg  <= !(|status_next);
      ovw_trip_reg <= ovw_trip;
      uvw_trip_reg <= uvw_trip;
      uvf_trip_reg <= uvf_trip;
    end
  end

  // Outputs straight from flops
  assign rd_data        = rd_data_reg;
  assign cmd_ack        = ack_reg;
  assign power_stage_on = power_on_reg;
  assign restart_count  = retry_reg;
  assign status         = status_reg;
  assign alert_n        = alert_n_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_ovw_sets_bits: assert property (
    ovw_evt |=> status_reg.ov_warn && status_reg.vout_summary ##1 !alert_n)
    else $error("high warning did not flag and alert");
  a_ovw_pct_range: assert property (
    wr_good && hit_ovw |=> ovw_pct_reg >= limit_pkg::OVW_MIN &&
                           ovw_pct_reg <= limit_pkg::OVW_MAX)
    else $error("high warning step out of range");
  a_limits_hold: assert property (
    !req && !nvm_restore |=> $stable(ovw_raw_reg) && $stable(uvf_raw_reg))
    else $error("limit changed without a write");
  a_uvw_sets_bits: assert property (
    uvw_evt |=> status_reg.uv_warn && status_reg.vout_summary)
    else $error("low warning not flagged");
  a_uvf_pct_range: assert property (
    wr_good && hit_uvf |=> uvf_pct_reg >= limit_pkg::UVF_MIN &&
                           uvf_pct_reg <= limit_pkg::UVF_MAX)
    else $error("fault step out of range");
  a_uvf_sets_bits: assert property (
    uvf_evt |=> status_reg.none_of_above && status_reg.uv_fault
            && status_reg.vout_summary)
    else $error("fault bits not set");
  a_immediate_off: assert property (
    uvf_evt && act == limit_pkg::ACT_IMMEDIATE |=> !power_stage_on)
    else $error("immediate shutdown missed");
  a_latch_no_retry: assert property (
    shut_now && retry_code == 3'h0 && output_on_cmd
      |=> state_reg == limit_pkg::ST_LATCHED
      ##1 (state_reg == limit_pkg::ST_LATCHED || !$past(output_on_cmd)))
    else $error("retry code zero did not latch");
  a_delay_bound: assert property (
    state_reg == limit_pkg::ST_DELAY
      |-> unit_reg < limit_pkg::delay_periods(dly_code))
    else $error("shutdown delay overran");
  a_hiccup_bound: assert property (
    state_reg == limit_pkg::ST_HICCUP
      |-> unit_reg < limit_pkg::hiccup_mult(dly_code))
    else $error("hiccup overran");
  a_bad_write: assert property (
    wr_bad |=> status_reg.cml_data && $stable(action_reg) ##1 !alert_n)
    else $error("bad write not refused");
  a_success_clear: assert property (
    state_reg == limit_pkg::ST_CONFIRM && rise_done && !uvf_evt
      |=> restart_count == 3'h0)
    else $error("retry count not cleared");
  a_alert_holds: assert property (
    |status_reg && ~|status_clear |=> !alert_n)
    else $error("alert dropped while status set");

endmodule

// >>> common/limit_pkg.sv
// Constants and types for the output-voltage limit and fault monitor.
// Assumes thresholds are held in tenths of a percent of the target.
package limit_pkg;

  // Command codes served by this block
  localparam logic [7:0] CMD_OV_WARN   = 8'h42;
  localparam logic [7:0] CMD_UV_WARN   = 8'h43;
  localparam logic [7:0] CMD_UV_FAULT  = 8'h44;
  localparam logic [7:0] CMD_UV_ACTION = 8'h45;

  // Supported threshold steps, tenths of a percent
  localparam logic [10:0] OVW_MIN   = 11'h406;
  localparam logic [10:0] OVW_MAX   = 11'h488;
  localparam logic [10:0] UVW_MIN   = 11'h348;
  localparam logic [10:0] UVW_MAX   = 11'h3CA;
  localparam logic [10:0] UVF_MIN   = 11'h258;
  localparam logic [10:0] UVF_MAX   = 11'h3B6;
  localparam logic [4:0]  STEP_ONE  = 5'h0A;
  localparam logic [4:0]  STEP_UVF  = 5'h19;
  localparam logic [3:0]  OVW_COUNT = 4'hE;
  localparam logic [3:0]  UVW_COUNT = 4'hE;
  localparam logic [3:0]  UVF_COUNT = 4'hF;
  localparam logic [9:0]  PCT_SCALE = 10'h3E8;
  // One hundred percent in the relative format
  localparam logic [15:0] REL_ONE   = 16'h0200;

  // Values after reset, consistent raw and hardware pairs
  localparam logic [15:0] OVW_RAW_RST = 16'h0233;
  localparam logic [15:0] UVW_RAW_RST = 16'h01CD;
  localparam logic [15:0] UVF_RAW_RST = 16'h019A;
  localparam logic [10:0] OVW_PCT_RST = 11'h44C;
  localparam logic [10:0] UVW_PCT_RST = 11'h384;
  localparam logic [10:0] UVF_PCT_RST = 11'h320;
  localparam logic [7:0]  ACTION_RST  = 8'h80;

  // Action byte layout and codes
  localparam int          ACT_LSB       = 6;
  localparam int          RETRY_LSB     = 3;
  localparam logic [2:0]  RETRY_FOREVER = 3'h7;
  localparam logic [2:0]  DLY_SHORT     = 3'h1;
  localparam logic [2:0]  DLY_MID       = 3'h3;
  localparam logic [2:0]  DLY_LONG      = 3'h7;

  typedef enum logic [1:0] {
    ACT_CONTINUE  = 2'b00,
    ACT_DELAYED   = 2'b01,
    ACT_IMMEDIATE = 2'b10,
    ACT_INVALID   = 2'b11
  } uv_action_e;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_RISE    = 3'b001,
    ST_CONFIRM = 3'b010,
    ST_RUN     = 3'b011,
    ST_DELAY   = 3'b100,
    ST_HICCUP  = 3'b101,
    ST_LATCHED = 3'b110
  } state_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        word;
    logic [7:0]  code;
    logic [15:0] data;
  } cmd_s;

  typedef struct packed {
    logic vout_summary;
    logic none_of_above;
    logic ov_warn;
    logic uv_warn;
    logic uv_fault;
    logic cml_data;
  } status_s;

  typedef struct packed {
    logic [15:0] ovw_raw;
    logic [15:0] uvw_raw;
    logic [15:0] uvf_raw;
    logic [10:0] ovw_pct;
    logic [10:0] uvw_pct;
    logic [10:0] uvf_pct;
    logic [7:0]  action;
  } nvm_image_s;

  // Shutdown delay in switching periods
  function automatic logic [2:0] delay_periods(input logic [2:0] code);
    if (code <= 3'h1) begin
      return DLY_SHORT;
    end
    if (code <= 3'h4) begin
      return DLY_MID;
    end
    return DLY_LONG;
  endfunction

  // Hiccup length in rise times; middle codes taken at face value
  function automatic logic [2:0] hiccup_mult(input logic [2:0] code);
    return (code == 3'h0) ? 3'h1 : code;
  endfunction

endpackage

// >>> rtl/limit_quantize.sv
// Maps a written limit to a supported hardware step, rounding up or down as selected.
// Assumes one write at a time; purely combinational.
`timescale 1ns/1ps
module limit_quantize (
  // Written value and reference
  input  wire logic [15:0] value,
  input  wire logic [15:0] base,
  // Step table of the addressed limit
  input  wire logic [10:0] min,
  input  wire logic [4:0]  step,
  input  wire logic [3:0]  count,
  input  wire logic        round_up,
  // Result
  output logic [10:0]      pct,
  output logic             ok
);
  logic [26:0] target;
  logic [26:0] prod;
  logic [26:0] lo;
  logic [26:0] hi;
  logic [10:0] s;
  logic        found;

  // Scale the value so it compares against base times step
  assign target = 27'(value) * 27'(limit_pkg::PCT_SCALE);

  // Walk the steps; rounding direction picks first or last match
  always_comb begin
    found = 1'b0;
    pct   = min;
    lo    = 27'h0;
    hi    = 27'h0;
    s     = min;
    prod  = 27'h0;
    for (int i = 0; i < 15; i++) begin
      if (4'(i) < count) begin
        s    = min + 11'(i) * {6'h00, step};
        prod = 27'(base) * 27'(s);
        if (i == 0) begin
          lo = prod;
        end
        hi = prod;
        if (round_up) begin
          if (!found && prod >= target) begin
            pct   = s;
            found = 1'b1;
          end
        end else if (prod <= target) begin
          pct   = s;
          found = 1'b1;
        end
      end
    end
  end

  // Values outside the supported span are refused
  assign ok = found && (base != 16'h0000) && target >= lo && target <= hi;

endmodule

// >>> rtl/limit_compare.sv
// Compares the sensed output against a percentage of the target.
// Assumes sense and target share one unit.
`timescale 1ns/1ps
module limit_compare (
  // Operands
  input  wire logic [15:0] sense,
  input  wire logic [15:0] target,
  input  wire logic [10:0] pct,
  input  wire logic        below,
  // Result
  output logic             trip
);
  logic [26:0] lhs;
  logic [26:0] rhs;

  // Threshold moves with the target, no stored voltage
  assign lhs  = 27'(sense) * 27'(limit_pkg::PCT_SCALE);
  assign rhs  = 27'(target) * 27'(pct);
  assign trip = below ? (lhs < rhs) : (lhs > rhs);

endmodule

// >>> testbench/pmbus_host_model.sv
// Host side of the command port: issues one transfer at a time.
// Assumes the monitor acks exactly one cycle after a taken command.
`timescale 1ns/1ps
module pmbus_host_model (
  // Clock and answer
  input  wire logic        clk,
  input  wire logic        cmd_ack,
  input  wire logic [15:0] rd_data,
  // Request
  output limit_pkg::cmd_s  cmd
);
  initial cmd = '0;

  // Limits travel as words, the action as a byte; flip breaks that on purpose
  task automatic xfer(input logic wr, input logic [7:0] code,
                      input logic flip, input logic [15:0] data,
                      output logic [15:0] rd, output logic ack);
    @(posedge clk);
    #1 cmd = '{1'b1, wr, (code != limit_pkg::CMD_UV_ACTION) ^ flip,
               code, data};
    @(posedge clk);
    #1 ack = cmd_ack;
    rd = rd_data;
    // Released write, code and data fields show the inverse so stale values cannot pass
    cmd = '{1'b0, ~wr, 1'b0, ~code, ~data};
  endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the output-voltage limit monitor.
// Assumes relative format and a four-cycle rise time.
`timescale 1ns/1ps
module testbench;
  logic               clk = 1'b0;
  logic               reset_n = 1'b0;
  logic               on_cmd = 1'b0;
  logic               vrel = 1'b1;
  logic               pwm_tick = 1'b0;
  logic [15:0]        vcmd = 16'h03E8;
  logic [15:0]        sense = 16'h03E8;
  logic [15:0]        rd_data, rd;
  logic               cmd_ack, stage_on, alert_n, ack;
  logic [2:0]         restart_count;
  limit_pkg::cmd_s    cmd;
  limit_pkg::status_s status;
  limit_pkg::status_s status_clear = '0;
  int                 n_errors = 0;
  int                 checks = 0;
  int                 cycles = 0;

  vout_limit_fault_monitor dut_u (.clk(clk), .reset_n(reset_n), .cmd(cmd),
    .rd_data(rd_data), .cmd_ack(cmd_ack), .vout_command(vcmd),
    .vout_relative(vrel), .vout_sense(sense), .output_on_cmd(on_cmd),
    .pwm_tick(pwm_tick), .ton_rise_cycles(16'h0004),
    .power_stage_on(stage_on), .restart_count(restart_count),
    .nvm_restore(1'b0), .nvm_image('0), .status_clear(status_clear),
    .status(status), .alert_n(alert_n));
  pmbus_host_model host_u (.clk(clk), .cmd_ack(cmd_ack), .rd_data(rd_data),
    .cmd(cmd));

  // Clock, switching tick every fourth cycle, hang limit
  always #50 clk = ~clk;
  always @(posedge clk) begin
    pwm_tick <= (cycles % 4 == 0);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Clear every status bit for one cycle
  task automatic clr;
    status_clear = '1;
    wait_n(1);
    status_clear = '0;
    wait_n(1);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1 reset_n = 1'b1;
    // Values after reset
    host_u.xfer(0, limit_pkg::CMD_OV_WARN, 0, 0, rd, ack);
    chk(rd, 16'h0233);
    chk(ack, 1'b1);
    host_u.xfer(0, limit_pkg::CMD_UV_ACTION, 0, 0, rd, ack);
    chk(rd, 16'h0080);
    // 103.125 percent is accepted and kept as written
    host_u.xfer(1, limit_pkg::CMD_OV_WARN, 0, 16'h0210, rd, ack);
    host_u.xfer(0, limit_pkg::CMD_OV_WARN, 0, 0, rd, ack);
    chk(rd, 16'h0210);
    chk(status, '0);
    // 100 percent lies below the span and is refused
    host_u.xfer(1, limit_pkg::CMD_OV_WARN, 0, 16'h0200, rd, ack);
    wait_n(2);
    chk(status.cml_data, 1'b1);
    chk(alert_n, 1'b0);
    host_u.xfer(0, limit_pkg::CMD_OV_WARN, 0, 0, rd, ack);
    chk(rd, 16'h0210);
    clr();
    chk(alert_n, 1'b1);
    // Action as a word, then the invalid action code
    host_u.xfer(1, limit_pkg::CMD_UV_ACTION, 1, 16'h0040, rd, ack);
    host_u.xfer(1, limit_pkg::CMD_UV_ACTION, 0, 16'h00C0, rd, ack);
    host_u.xfer(0, limit_pkg::CMD_UV_ACTION, 0, 0, rd, ack);
    chk(rd, 16'h0080);
    wait_n(2);
    chk(status.cml_data, 1'b1);
    clr();
    // Absolute 103.5 percent of the target rounds up to 104 percent
    vrel = 1'b0;
    host_u.xfer(1, limit_pkg::CMD_OV_WARN, 0, 16'h040B, rd, ack);
    vcmd = 16'h0384;
    host_u.xfer(0, limit_pkg::CMD_OV_WARN, 0, 0, rd, ack);
    chk(rd, 16'h040B);
    chk(status.cml_data, 1'b0);
    vcmd = 16'h03E8;
    vrel = 1'b1;
    // Start up; 103.5 percent stays under the rounded-up 104 percent
    on_cmd = 1'b1;
    sense = 16'h040B;
    wait_n(14);
    chk(status.ov_warn, 1'b0);
    sense = 16'h0415;
    wait_n(3);
    chk(status.ov_warn, 1'b1);
    chk(status.vout_summary, 1'b1);
    chk(alert_n, 1'b0);
    sense = 16'h03E8;
    wait_n(3);
    clr();
    // Lower target moves the trip point below the sensed output
    vcmd = 16'h0384;
    wait_n(3);
    chk(status.ov_warn, 1'b1);
    vcmd = 16'h03E8;
    wait_n(3);
    clr();
    // Low limit 91.02 percent rounds down: 91.7 percent gives no warning
    host_u.xfer(1, limit_pkg::CMD_UV_WARN, 0, 16'h01D2, rd, ack);
    sense = 16'h0395;
    wait_n(3);
    chk(status.uv_warn, 1'b0);
    // Low warning only, then fault with immediate latch-off
    sense = 16'h0352;
    wait_n(3);
    chk({status.uv_warn, status.uv_fault}, 2'b10);
    chk(stage_on, 1'b1);
    sense = 16'h02BC;
    wait_n(3);
    chk(status.uv_fault, 1'b1);
    chk(status.none_of_above, 1'b1);
    chk(stage_on, 1'b0);
    wait_n(20);
    chk({stage_on, restart_count}, 4'h0);
    // Delayed shutdown, one retry, three periods, hiccup of two rises
    on_cmd = 1'b0;
    host_u.xfer(1, limit_pkg::CMD_UV_ACTION, 0, 16'h004A, rd, ack);
    on_cmd = 1'b1;
    wait_n(8);
    chk(stage_on, 1'b1);
    wait_n(80);
    chk({stage_on, restart_count}, 4'h1);
    tally_and_finish();
  end
endmodule
